//--- pkg/sic_consts.svh
// Summary of operation
// - serializing: finish earlier work, drain stores first
// - protected-mode switch waits for real-mode work
// - serializing discards speculative results
// - listed privileged serializers fault outside kernel
// - task priority register move never serializes
// - query, return, resume serialize at any level
// - no access passes a serializing instruction
// - ident query only writes registers A-D
// - fences drain memory, never serialize issue
// - other serializers never write back dirty lines
// - writeback-invalidate writes back and serializes
// - paging toggle applies from the refetch after the write
// - every control zero write fully serializes
// - base write switches tables for next fetch only while paging is on
// - base write keeps global translations valid
// - branches prefetch freely, no serialization
// - store fence orders stores, not loads
// - load fence orders loads, not stores
// - full fence orders loads and stores
`ifndef SIC_CONSTS_SVH
`define SIC_CONSTS_SVH

// ----------------------------------------------------------------
// control register numbers
// ----------------------------------------------------------------
`define SIC_CR_ZERO       4'h0
`define SIC_CR_TBASE      4'h3
`define SIC_CR_TPRIO      4'h8

// ----------------------------------------------------------------
// privilege and reset values
// ----------------------------------------------------------------
`define SIC_CPL_KERNEL    2'h0
`define SIC_PAGING_RST    1'b0

`endif

//--- pkg/sic_pkg.sv
`default_nettype none
package sic_pkg;

  // instruction classes seen by the serialization control
  typedef enum logic [4:0] {
    K_OTHER,
    K_BRANCH,
    K_CACHE_DISCARD,
    K_EPT_INV,
    K_PAGE_INV,
    K_VPID_INV,
    K_GDT_LOAD,
    K_IDT_LOAD,
    K_LDT_LOAD,
    K_TR_LOAD,
    K_CR_MOVE,
    K_DR_MOVE,
    K_CACHE_WBINV,
    K_MODEL_WRITE,
    K_IDENT_QUERY,
    K_INT_RETURN,
    K_MGMT_RESUME,
    K_STORE_FENCE,
    K_LOAD_FENCE,
    K_FULL_FENCE
  } sic_kind_e;

  // serialization sequencer states
  typedef enum logic [2:0] {
    S_RUN,
    S_DRAIN,
    S_WBACK,
    S_EXEC,
    S_REFETCH
  } sic_state_e;

endpackage
`default_nettype wire

//--- hw/sic_classify.sv
`include "sic_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// instruction class decode, purely combinational
// ----------------------------------------------------------------
module sic_classify (
  // instruction under decode
  input  wire logic [4:0] kind,
  input  wire logic [3:0] crNum,
  // decoded properties
  output logic            serialize,
  output logic            privileged,
  output logic            fenceLoad,
  output logic            fenceStore,
  output logic            writeBack,
  output logic            cr0Write,
  output logic            cr3Write,
  output logic            identQuery
);

  // unknown codes act as plain work
  always_comb begin
    serialize  = 1'b0;
    privileged = 1'b0;
    fenceLoad  = 1'b0;
    fenceStore = 1'b0;
    writeBack  = 1'b0;
    cr0Write   = 1'b0;
    cr3Write   = 1'b0;
    identQuery = 1'b0;
    case (kind)
      sic_pkg::K_CACHE_DISCARD, sic_pkg::K_EPT_INV, sic_pkg::K_PAGE_INV,
      sic_pkg::K_VPID_INV, sic_pkg::K_GDT_LOAD, sic_pkg::K_IDT_LOAD,
      sic_pkg::K_LDT_LOAD, sic_pkg::K_TR_LOAD, sic_pkg::K_DR_MOVE,
      sic_pkg::K_MODEL_WRITE: begin
        serialize  = 1'b1;
        privileged = 1'b1;
      end
      sic_pkg::K_CR_MOVE: begin
        // priority moves need no drain
        serialize  = (crNum != `SIC_CR_TPRIO);
        privileged = 1'b1;
        cr0Write   = (crNum == `SIC_CR_ZERO);
        cr3Write   = (crNum == `SIC_CR_TBASE);
      end
      sic_pkg::K_CACHE_WBINV: begin
        serialize  = 1'b1;
        privileged = 1'b1;
        writeBack  = 1'b1;
      end
      sic_pkg::K_IDENT_QUERY: begin
        serialize  = 1'b1;
        identQuery = 1'b1;
      end
      sic_pkg::K_INT_RETURN, sic_pkg::K_MGMT_RESUME: begin
        serialize  = 1'b1;
      end
      // fences never serialize the instruction stream
      sic_pkg::K_STORE_FENCE: fenceStore = 1'b1;
      sic_pkg::K_LOAD_FENCE:  fenceLoad  = 1'b1;
      sic_pkg::K_FULL_FENCE: begin
        fenceLoad  = 1'b1;
        fenceStore = 1'b1;
      end
      // branches prefetch freely
      sic_pkg::K_BRANCH: serialize = 1'b0;
      default: serialize = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

//--- hw/sic_fence_gate.sv
`default_nettype none
// ----------------------------------------------------------------
// fence gates: hold later loads or stores back, issue keeps going
// ----------------------------------------------------------------
module sic_fence_gate (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // fence starts, one-cycle pulses
  input  wire logic startLoad,
  input  wire logic startStore,
  input  wire logic startFull,
  // memory subsystem status
  input  wire logic loadsPending,
  input  wire logic storeBufEmpty,
  // gates toward the load and store units
  output logic      loadGate,
  output logic      storeGate
);

  logic loadHold_q;  // load fence pending
  logic loadHold_d;
  logic storeHold_q; // store fence pending
  logic storeHold_d;
  logic fullHold_q;  // full fence pending
  logic fullHold_d;

  // a start in the clearing cycle wins, so no fence is lost
  always_comb begin
    loadHold_d  = startLoad | (loadHold_q & loadsPending);
    storeHold_d = startStore | (storeHold_q & ~storeBufEmpty);
    fullHold_d  = startFull |
                  (fullHold_q & (loadsPending | ~storeBufEmpty));
  end

  // state registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      loadHold_q  <= 1'b0;
      storeHold_q <= 1'b0;
      fullHold_q  <= 1'b0;
    end else begin
      loadHold_q  <= loadHold_d;
      storeHold_q <= storeHold_d;
      fullHold_q  <= fullHold_d;
    end
  end

  // full fence blocks both kinds; single fences only their own
  assign loadGate  = loadHold_q | fullHold_q;
  assign storeGate = storeHold_q | fullHold_q;

endmodule
`default_nettype wire

//--- hw/sic_ctrl.sv
`include "sic_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// serializing instruction control, top level
// ----------------------------------------------------------------
module sic_ctrl (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // instruction offered by decode
  input  wire logic       insnValid,
  input  wire logic [4:0] insnKind,
  input  wire logic [3:0] insnCrNum,
  input  wire logic [1:0] insnCpl,
  input  wire logic       insnNewPaging,
  // pipeline and memory status
  input  wire logic       olderPending,
  input  wire logic       storeBufEmpty,
  input  wire logic       memIdle,
  input  wire logic       loadsPending,
  input  wire logic       cacheWbDone,
  // issue handshake and stall
  output logic            insnReady,
  output logic            issueStall,
  // pipeline clean-up pulses
  output logic            specFlush,
  output logic            prefetchFlush,
  output logic            refetch,
  output logic            serDone,
  output logic            privFault,
  // cache and translation side effects
  output logic            cacheWbReq,
  output logic            tlbFlushLocal,
  output logic            tableSwitch,
  output logic            fetchPaging,
  output logic            identWrite,
  // fence gates toward the load and store units
  output logic            loadGate,
  output logic            storeGate
);

  // ----------------------------------------------------------------
  // decode of the offered instruction
  // ----------------------------------------------------------------
  logic isSer;      // class serializes
  logic isPriv;     // class needs kernel level when it serializes
  logic isFenceLd;  // load half of a fence
  logic isFenceSt;  // store half of a fence
  logic isWb;       // writeback-invalidate
  logic isCr0;      // control zero write
  logic isCr3;      // translation base write
  logic isIdent;    // identification query

  sic_classify u_classify (
    .kind       (insnKind),
    .crNum      (insnCrNum),
    .serialize  (isSer),
    .privileged (isPriv),
    .fenceLoad  (isFenceLd),
    .fenceStore (isFenceSt),
    .writeBack  (isWb),
    .cr0Write   (isCr0),
    .cr3Write   (isCr3),
    .identQuery (isIdent)
  );

  // ----------------------------------------------------------------
  // acceptance and fault decision
  // ----------------------------------------------------------------
  logic insnReady_q;     // ready toward decode
  logic insnReady_d;
  logic accept;   // instruction taken this cycle
  logic fault;    // privileged serializer outside kernel
  logic serTake;  // serializing instruction starts

  assign accept  = insnValid & insnReady_q;
  assign fault   = accept & isSer & isPriv & (insnCpl != `SIC_CPL_KERNEL);
  assign serTake = accept & isSer & ~fault;

  // fence starts toward the gate block
  logic fenceFull;   // both halves set
  logic fenceLdOnly; // load fence only
  logic fenceStOnly; // store fence only

  assign fenceFull   = accept & isFenceLd & isFenceSt;
  assign fenceLdOnly = accept & isFenceLd & ~isFenceSt;
  assign fenceStOnly = accept & isFenceSt & ~isFenceLd;

  logic loadGateRaw;  // gate straight from the fence block
  logic storeGateRaw;

  sic_fence_gate u_fence (
    .clock         (clock),
    .reset         (reset),
    .startLoad     (fenceLdOnly),
    .startStore    (fenceStOnly),
    .startFull     (fenceFull),
    .loadsPending  (loadsPending),
    .storeBufEmpty (storeBufEmpty),
    .loadGate      (loadGateRaw),
    .storeGate     (storeGateRaw)
  );

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  sic_pkg::sic_state_e state_q; // current step of the sequence
  sic_pkg::sic_state_e state_d;

  logic pendWb_q;      // writeback still owed
  logic pendWb_d;
  logic pendCr0_q;     // control zero write in flight
  logic pendCr0_d;
  logic pendCr3_q;     // translation base write in flight
  logic pendCr3_d;
  logic pendIdent_q;   // identification query in flight
  logic pendIdent_d;
  logic newPaging_q;   // paging flag carried by the write
  logic newPaging_d;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic issueStall_q;    // hold decode, issue and retire
  logic issueStall_d;
  logic specFlush_q;     // discard speculative work
  logic specFlush_d;
  logic prefetchFlush_q; // drop prefetched bytes
  logic prefetchFlush_d;
  logic refetch_q;       // restart fetch at next instruction
  logic refetch_d;
  logic serDone_q;       // serializing instruction finished
  logic serDone_d;
  logic privFault_q;     // privilege fault raised
  logic privFault_d;
  logic cacheWbReq_q;    // write dirty lines back
  logic cacheWbReq_d;
  logic tlbFlushLocal_q; // drop non-global translations
  logic tlbFlushLocal_d;
  logic tableSwitch_q;   // fetch now uses new tables
  logic tableSwitch_d;
  logic fetchPaging_q;   // paging setting used by fetch
  logic fetchPaging_d;
  logic identWrite_q;    // write registers A to D
  logic identWrite_d;
  logic loadGate_q;      // registered load gate
  logic loadGate_d;
  logic storeGate_q;     // registered store gate
  logic storeGate_d;

  // all older work done, stores out, memory idle
  logic drained;
  assign drained = ~olderPending & storeBufEmpty & memIdle;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // pulses default low, levels hold; one step per cycle keeps the
  // sequence easy to follow at the price of a few extra cycles
  always_comb begin
    state_d         = state_q;
    pendWb_d        = pendWb_q;
    pendCr0_d       = pendCr0_q;
    pendCr3_d       = pendCr3_q;
    pendIdent_d     = pendIdent_q;
    newPaging_d     = newPaging_q;
    specFlush_d     = 1'b0;
    prefetchFlush_d = 1'b0;
    refetch_d       = 1'b0;
    serDone_d       = 1'b0;
    privFault_d     = fault;
    cacheWbReq_d    = cacheWbReq_q;
    tlbFlushLocal_d = 1'b0;
    tableSwitch_d   = 1'b0;
    fetchPaging_d   = fetchPaging_q;
    identWrite_d    = 1'b0;
    case (state_q)
      sic_pkg::S_RUN: begin
        if (serTake) begin
          // nothing younger may run past this point
          state_d     = sic_pkg::S_DRAIN;
          specFlush_d = 1'b1;
          pendWb_d    = isWb;
          pendCr0_d   = isCr0;
          pendCr3_d   = isCr3;
          pendIdent_d = isIdent;
          newPaging_d = insnNewPaging;
        end
      end
      sic_pkg::S_DRAIN: begin
        // wait for older work and buffered writes
        if (drained) begin
          if (pendWb_q) begin
            state_d      = sic_pkg::S_WBACK;
            cacheWbReq_d = 1'b1;
          end else begin
            state_d = sic_pkg::S_EXEC;
          end
        end
      end
      sic_pkg::S_WBACK: begin
        // held until the cache is clean
        if (cacheWbDone) begin
          cacheWbReq_d = 1'b0;
          pendWb_d     = 1'b0;
          state_d      = sic_pkg::S_EXEC;
        end
      end
      sic_pkg::S_EXEC: begin
        // effects land only after the drain
        if (pendCr0_q) begin
          fetchPaging_d = newPaging_q;
        end
        if (pendCr3_q) begin
          tlbFlushLocal_d = 1'b1;
          tableSwitch_d   = fetchPaging_q;
        end
        identWrite_d = pendIdent_q;
        state_d      = sic_pkg::S_REFETCH;
      end
      sic_pkg::S_REFETCH: begin
        // stale prefetched bytes may hold the old mapping
        prefetchFlush_d = 1'b1;
        refetch_d       = 1'b1;
        serDone_d       = 1'b1;
        pendCr0_d       = 1'b0;
        pendCr3_d       = 1'b0;
        pendIdent_d     = 1'b0;
        state_d         = sic_pkg::S_RUN;
      end
      default: begin
        state_d      = sic_pkg::S_RUN;
        cacheWbReq_d = 1'b0;
      end
    endcase
    // offers resume once back in run
    insnReady_d  = (state_d == sic_pkg::S_RUN);
    issueStall_d = (state_d != sic_pkg::S_RUN);
    // fences only gate data accesses, issue is untouched
    loadGate_d   = loadGateRaw | fenceLdOnly | fenceFull;
    storeGate_d  = storeGateRaw | fenceStOnly | fenceFull;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q         <= sic_pkg::S_RUN;
      pendWb_q        <= 1'b0;
      pendCr0_q       <= 1'b0;
      pendCr3_q       <= 1'b0;
      pendIdent_q     <= 1'b0;
      newPaging_q     <= `SIC_PAGING_RST;
      insnReady_q     <= 1'b0;
      issueStall_q    <= 1'b0;
      specFlush_q     <= 1'b0;
      prefetchFlush_q <= 1'b0;
      refetch_q       <= 1'b0;
      serDone_q       <= 1'b0;
      privFault_q     <= 1'b0;
      cacheWbReq_q    <= 1'b0;
      tlbFlushLocal_q <= 1'b0;
      tableSwitch_q   <= 1'b0;
      fetchPaging_q   <= `SIC_PAGING_RST;
      identWrite_q    <= 1'b0;
      loadGate_q      <= 1'b0;
      storeGate_q     <= 1'b0;
    end else begin
      state_q         <= state_d;
      pendWb_q        <= pendWb_d;
      pendCr0_q       <= pendCr0_d;
      pendCr3_q       <= pendCr3_d;
      pendIdent_q     <= pendIdent_d;
      newPaging_q     <= newPaging_d;
      insnReady_q     <= insnReady_d;
      issueStall_q    <= issueStall_d;
      specFlush_q     <= specFlush_d;
      prefetchFlush_q <= prefetchFlush_d;
      refetch_q       <= refetch_d;
      serDone_q       <= serDone_d;
      privFault_q     <= privFault_d;
      cacheWbReq_q    <= cacheWbReq_d;
      tlbFlushLocal_q <= tlbFlushLocal_d;
      tableSwitch_q   <= tableSwitch_d;
      fetchPaging_q   <= fetchPaging_d;
      identWrite_q    <= identWrite_d;
      loadGate_q      <= loadGate_d;
      storeGate_q     <= storeGate_d;
    end
  end

  // ----------------------------------------------------------------
  // output wiring
  // ----------------------------------------------------------------
  assign insnReady     = insnReady_q;
  assign issueStall    = issueStall_q;
  assign specFlush     = specFlush_q;
  assign prefetchFlush = prefetchFlush_q;
  assign refetch       = refetch_q;
  assign serDone       = serDone_q;
  assign privFault     = privFault_q;
  assign cacheWbReq    = cacheWbReq_q;
  assign tlbFlushLocal = tlbFlushLocal_q;
  assign tableSwitch   = tableSwitch_q;
  assign fetchPaging   = fetchPaging_q;
  assign identWrite    = identWrite_q;
  assign loadGate      = loadGate_q;
  assign storeGate     = storeGate_q;

endmodule
`default_nettype wire

//--- sim/sic_ctrl_monitor.sv
`default_nettype none
// ------------------------------------------
// serialization checker on the top ports
// ------------------------------------------
module sic_ctrl_monitor (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // offered instruction
  input wire logic       insnValid,
  input wire logic [4:0] insnKind,
  input wire logic [3:0] insnCrNum,
  input wire logic [1:0] insnCpl,
  // memory status
  input wire logic       olderPending,
  input wire logic       storeBufEmpty,
  input wire logic       memIdle,
  input wire logic       cacheWbDone,
  // design outputs
  input wire logic       insnReady,
  input wire logic       issueStall,
  input wire logic       specFlush,
  input wire logic       serDone,
  input wire logic       privFault,
  input wire logic       cacheWbReq,
  input wire logic       tlbFlushLocal,
  input wire logic       tableSwitch,
  input wire logic       fetchPaging,
  input wire logic       identWrite,
  input wire logic       storeGate
);
  logic take;    // offer accepted this edge
  logic isSer;   // serializing class
  logic isFree;  // allowed at any level
  logic serOk;   // serializer that will run
  logic drained; // nothing older left
  assign take = insnValid && insnReady;
  // register 8 moves are plain
  assign isSer = insnKind >= sic_pkg::K_CACHE_DISCARD && insnKind <= sic_pkg::K_MGMT_RESUME
                 && !(insnKind == sic_pkg::K_CR_MOVE && insnCrNum == 4'h8);
  assign isFree = insnKind >= sic_pkg::K_IDENT_QUERY && insnKind <= sic_pkg::K_MGMT_RESUME;
  assign serOk = take && isSer && (isFree || insnCpl == 2'h0);
  assign drained = !olderPending && storeBufEmpty && memIdle;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ------------------------------------------
  // sequences: take, then drained
  // ------------------------------------------
  sequence s_nowb;
    serOk && insnKind != sic_pkg::K_CACHE_WBINV ##1 drained;
  endsequence
  sequence s_go(k);
    serOk && insnKind == k ##1 drained;
  endsequence
  // ------------------------------------------
  // assertions
  // ------------------------------------------
  AST_SER_START: assert property (serOk |=> specFlush && issueStall && !insnReady)
    else $error("start wrong");
  AST_PRIV_FAULT: assert property (
    take && isSer && !isFree && insnCpl != 2'h0 |=> privFault && insnReady && !specFlush)
    else $error("fault wrong");
  AST_TPRIO: assert property (
    take && insnKind == sic_pkg::K_CR_MOVE && insnCrNum == 4'h8 |=> insnReady && !specFlush)
    else $error("priority move serialized");
  AST_FENCE: assert property (
    take && insnKind >= sic_pkg::K_STORE_FENCE |=> insnReady && !issueStall && !specFlush)
    else $error("fence stalled issue");
  AST_FENCE_ST: assert property (
    take && insnKind == sic_pkg::K_STORE_FENCE |=> storeGate)
    else $error("store gate not set");
  AST_DRAIN_WAIT: assert property (issueStall && !drained |=> !serDone && !insnReady)
    else $error("finished before drain");
  AST_SER_END: assert property (
    s_nowb |-> ##3 serDone && insnReady && !issueStall)
    else $error("end wrong");
  AST_NO_WB: assert property (s_nowb |-> !cacheWbReq[*4])
    else $error("writeback without request");
  AST_WB_HOLD: assert property (cacheWbReq && !cacheWbDone |=> cacheWbReq && !serDone)
    else $error("writeback dropped early");
  AST_IDENT: assert property (s_go(sic_pkg::K_IDENT_QUERY) |-> ##2 identWrite)
    else $error("ident write missing");
  AST_TBASE: assert property (
    s_go(sic_pkg::K_CR_MOVE) and (insnCrNum == 4'h3 && fetchPaging ##1 1'b1)
    |-> ##2 tableSwitch && tlbFlushLocal)
    else $error("base write wrong");
endmodule
bind sic_ctrl sic_ctrl_monitor u_sic_ctrl_monitor (.clock, .reset, .insnValid, .insnKind,
  .insnCrNum, .insnCpl, .olderPending, .storeBufEmpty, .memIdle, .cacheWbDone, .insnReady,
  .issueStall, .specFlush, .serDone, .privFault, .cacheWbReq, .tlbFlushLocal, .tableSwitch,
  .fetchPaging, .identWrite, .storeGate);
`default_nettype wire

//--- sim/sic_mem_model.sv
`default_nettype none
// ------------------------------------------
// memory subsystem: store buffer, loads, writeback
// ------------------------------------------
module sic_mem_model #(
  parameter int WB_LAT = 6  // cycles a writeback takes
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // bench preload
  input  wire logic       go,
  input  wire logic [7:0] stAdd,
  input  wire logic [7:0] ldAdd,
  // writeback request
  input  wire logic       cacheWbReq,
  // status toward the control
  output logic            storeBufEmpty,
  output logic            memIdle,
  output logic            loadsPending,
  output logic            cacheWbDone
);
  logic [7:0] stCnt;  // buffered stores
  logic [7:0] ldCnt;  // loads in flight
  int         wbCnt;  // writeback progress
  // one store and one load retire per cycle, so drains take real time
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stCnt <= 8'h00;
      ldCnt <= 8'h00;
      wbCnt <= 0;
      cacheWbDone <= 1'b0;
    end else begin
      stCnt <= go ? stAdd : ((stCnt != 8'h00) ? stCnt - 8'h01 : 8'h00);
      ldCnt <= go ? ldAdd : ((ldCnt != 8'h00) ? ldCnt - 8'h01 : 8'h00);
      // one-cycle done pulse, count restarts
      wbCnt <= (cacheWbReq && !cacheWbDone) ? wbCnt + 1 : 0;
      cacheWbDone <= cacheWbReq && !cacheWbDone && wbCnt == WB_LAT - 1;
    end
  end
  assign storeBufEmpty = stCnt == 8'h00;
  assign loadsPending = ldCnt != 8'h00;
  assign memIdle = storeBufEmpty && !loadsPending;
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------
  // signals
  // ------------------------------------------
  logic       clock, reset, insnValid, insnNewPaging, olderPending, go;
  logic [4:0] insnKind;
  logic [3:0] insnCrNum;
  logic [1:0] insnCpl;
  logic [7:0] stAdd, ldAdd;
  logic       insnReady, issueStall, specFlush, prefetchFlush, refetch, serDone;
  logic       privFault, cacheWbReq, tlbFlushLocal, tableSwitch, fetchPaging, identWrite;
  logic       loadGate, storeGate, storeBufEmpty, memIdle, loadsPending, cacheWbDone;
  logic [9:0] seen;         // watched outputs, expectation order
  int         cnt [10];     // cycles each output was high
  int         mismatches;
  int         checks_done;
  assign seen = {issueStall, cacheWbReq, identWrite, tableSwitch, tlbFlushLocal,
                 privFault, serDone, refetch, prefetchFlush, specFlush};
  sic_ctrl u_sic_ctrl (.clock, .reset, .insnValid, .insnKind, .insnCrNum, .insnCpl,
    .insnNewPaging, .olderPending, .storeBufEmpty, .memIdle, .loadsPending, .cacheWbDone,
    .insnReady, .issueStall, .specFlush, .prefetchFlush, .refetch, .serDone, .privFault,
    .cacheWbReq, .tlbFlushLocal, .tableSwitch, .fetchPaging, .identWrite, .loadGate,
    .storeGate);
  sic_mem_model u_sic_mem_model (.clock, .reset, .go, .stAdd, .ldAdd, .cacheWbReq,
    .storeBufEmpty, .memIdle, .loadsPending, .cacheWbDone);
  always #5 clock = ~clock;
  // count where outputs have settled
  always @(negedge clock) begin
    for (int i = 0; i < 10; i++)
      if (seen[i] === 1'b1) cnt[i]++;
  end
  // ------------------------------------------
  // shared tasks
  // ------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic mem_load(input logic [7:0] st, input logic [7:0] ld);
    @(posedge clock);
    go <= 1'b1;
    stAdd <= st;
    ldAdd <= ld;
    @(posedge clock);
    go <= 1'b0;
  endtask
  // hold the offer until ready is seen
  task automatic offer(input logic [4:0] k, input logic [3:0] cr, input logic [1:0] cp,
                       input logic np);
    @(posedge clock);
    foreach (cnt[i]) cnt[i] = 0;
    insnValid <= 1'b1;
    insnKind <= k;
    insnCrNum <= cr;
    insnCpl <= cp;
    insnNewPaging <= np;
    @(negedge clock);
    while (insnReady !== 1'b1) @(negedge clock);
    @(posedge clock);
    insnValid <= 1'b0;
  endtask
  // wait for the end, then compare counts
  task automatic finish(input logic [9:0] exp);
    repeat (2) @(negedge clock);
    repeat (200) if (insnReady !== 1'b1) @(negedge clock);
    @(negedge clock);
    chk("insnReady", insnReady, 1);
    for (int i = 0; i < 10; i++)
      chk($sformatf("output %0d", i), (i < 8) ? cnt[i] : (cnt[i] != 0), exp[i]);
  endtask
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_ser_all();
    for (int k = sic_pkg::K_CACHE_DISCARD; k <= sic_pkg::K_MGMT_RESUME; k++) begin
      if (k == sic_pkg::K_CACHE_WBINV) continue;
      mem_load(8'h06, 8'h03);
      offer(5'(k), 4'h2, 2'h0, 1'b0);
      finish((k == sic_pkg::K_IDENT_QUERY) ? 10'h28f : 10'h20f);
    end
  endtask
  task automatic t_priv_user();
    for (int k = sic_pkg::K_CACHE_DISCARD; k <= sic_pkg::K_MGMT_RESUME; k++) begin
      offer(5'(k), 4'h2, 2'h3, 1'b0);
      if (k < sic_pkg::K_IDENT_QUERY) finish(10'h010);
      else finish((k == sic_pkg::K_IDENT_QUERY) ? 10'h28f : 10'h20f);
    end
  endtask
  task automatic t_plain();
    offer(sic_pkg::K_CR_MOVE, 4'h8, 2'h3, 1'b0);
    finish(10'h000);
    offer(sic_pkg::K_BRANCH, 4'h0, 2'h3, 1'b0);
    finish(10'h000);
  endtask
  task automatic t_wb();
    mem_load(8'h04, 8'h02);
    offer(sic_pkg::K_CACHE_WBINV, 4'h0, 2'h0, 1'b0);
    finish(10'h30f);
  endtask
  task automatic t_paging();
    chk("paging reset", fetchPaging, 0);
    offer(sic_pkg::K_CR_MOVE, 4'h0, 2'h0, 1'b1);
    finish(10'h20f);
    chk("paging on", fetchPaging, 1);
    offer(sic_pkg::K_CR_MOVE, 4'h3, 2'h0, 1'b0);
    finish(10'h26f);
    offer(sic_pkg::K_CR_MOVE, 4'h0, 2'h0, 1'b0);
    finish(10'h20f);
    offer(sic_pkg::K_CR_MOVE, 4'h3, 2'h0, 1'b0);
    finish(10'h22f);
  endtask
  task automatic t_fences();
    for (int i = 0; i < 3; i++) begin
      mem_load(8'h0c, 8'h0c);
      offer(5'(sic_pkg::K_STORE_FENCE + i), 4'h0, 2'h0, 1'b0);
      @(negedge clock);
      chk("gates", {loadGate, storeGate, insnReady, issueStall}, {i != 0, i != 1, 2'b10});
      repeat (16) @(negedge clock);
      chk("gates free", {loadGate, storeGate}, 2'b00);
    end
  endtask
  task automatic t_drain();
    @(posedge clock);
    olderPending <= 1'b1;
    offer(sic_pkg::K_INT_RETURN, 4'h0, 2'h0, 1'b0);
    repeat (20) @(negedge clock);
    chk("held", {issueStall, insnReady, cnt[3] != 0}, 3'b100);
    @(posedge clock);
    olderPending <= 1'b0;
    finish(10'h20f);
  endtask
  // ------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {insnValid, insnNewPaging, olderPending, go} = 4'h0;
    {insnKind, insnCrNum, insnCpl, stAdd, ldAdd} = '0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_paging();
    t_ser_all();
    t_priv_user();
    t_plain();
    t_wb();
    t_fences();
    t_drain();
    close_out();
  end
  // a few hundred cycles needed
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
